// ===== src/edge_detect.sv
// edge detector on an already synchronised level
// input is in the i_core_clk domain
`timescale 1ns/1ps
module edge_detect (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_level,
    output logic o_edge
);
    typedef struct packed {
        logic prev;
        logic seen;
    } edge_state_t;

    edge_state_t s_q;
    edge_state_t s_d;

    always_comb
    begin
        s_d.prev = i_level;
        s_d.seen = 1'b1;
    end

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // first sample after reset only primes the history
    assign o_edge = s_q.seen & (i_level ^ s_q.prev);
endmodule

// ===== src/supervisor_consts.svh
// constants for the supervisor watchdog/reset core
// assumes a 100 MHz core clock
`ifndef SUPERVISOR_CONSTS_SVH
`define SUPERVISOR_CONSTS_SVH
`define CLK_FREQ_HZ 100000000
`define WD_TIMEOUT_MS 1600
`define RESET_PULSE_MS 200
`define WD_TIMEOUT_CYC ((`CLK_FREQ_HZ / 1000) * `WD_TIMEOUT_MS)
`define RESET_PULSE_CYC ((`CLK_FREQ_HZ / 1000) * `RESET_PULSE_MS)
`define CNT_W 32
`define CNT_ZERO 32'h0000_0000
`define CNT_ONE 32'h0000_0001
`define SYNC_STAGES 2
`endif

// ===== src/supervisor_pkg.sv
// types for the supervisor watchdog/reset core
// used with supervisor_consts.svh
package supervisor_pkg;
    typedef enum logic [1:0] {
        ST_POR,
        ST_RUN,
        ST_PULSE
    } sup_state_t;

    typedef struct packed {
        logic below_reset;
        logic below_switch;
        logic pfi_low;
        logic batt_above;
    } analog_flags_t;

    typedef struct packed {
        logic reset_n;
        logic reset_h;
        logic pf_warn_n;
        logic on_battery;
    } sup_outs_t;
endpackage

// ===== src/supervisor_watchdog_reset.sv
// digital core of a supervisor: watchdog, reset pulse, power-fail, supply select
// analog comparators arrive as asynchronous flags; one 100 MHz clock
`include "supervisor_consts.svh"
`timescale 1ns/1ps
module supervisor_watchdog_reset
    import supervisor_pkg::*;
#(
    parameter logic [`CNT_W-1:0] WD_TIMEOUT_CYC = `CNT_W'(`WD_TIMEOUT_CYC),
    parameter logic [`CNT_W-1:0] RESET_PULSE_CYC = `CNT_W'(`RESET_PULSE_CYC)
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_watchdog_kick_in,
    input wire analog_flags_t i_flags,
    output sup_outs_t o_status
);
    typedef struct packed {
        sup_state_t state;
        logic [`CNT_W-1:0] wd_cnt;
        logic [`CNT_W-1:0] rst_cnt;
        logic on_batt;
        sup_outs_t outs;
    } core_state_t;

    core_state_t s_q;
    core_state_t s_d;
    logic [4:0] sync_out;
    logic kick_s;
    logic kick_edge;
    analog_flags_t f;

    // kick and flag pins through two flops before use
    sync_2ff #(
        .WIDTH(5)
    ) u_sync (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_async({i_watchdog_kick_in, i_flags}),
        .o_sync(sync_out)
    );

    assign kick_s = sync_out[4];
    assign f = analog_flags_t'(sync_out[3:0]);

    edge_detect u_edge (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_level(kick_s),
        .o_edge(kick_edge)
    );

    always_comb
    begin
        s_d = s_q;
        case (s_q.state)
            ST_POR:
            begin
                s_d.wd_cnt = `CNT_ZERO;
                if (f.below_reset)
                begin
                    s_d.rst_cnt = `CNT_ZERO;
                end
                else if (s_q.rst_cnt >= RESET_PULSE_CYC - `CNT_ONE)
                begin
                    s_d.state = ST_RUN;
                    s_d.rst_cnt = `CNT_ZERO;
                end
                else
                begin
                    s_d.rst_cnt = s_q.rst_cnt + `CNT_ONE;
                end
            end
            ST_RUN:
            begin
                // watchdog always armed here, no disable path
                if (f.below_reset)
                begin
                    s_d.state = ST_POR;
                    s_d.rst_cnt = `CNT_ZERO;
                    s_d.wd_cnt = `CNT_ZERO;
                end
                else if (kick_edge)
                begin
                    s_d.wd_cnt = `CNT_ZERO;
                end
                else if (s_q.wd_cnt >= WD_TIMEOUT_CYC - `CNT_ONE)
                begin
                    s_d.state = ST_PULSE;
                    s_d.wd_cnt = `CNT_ZERO;
                    s_d.rst_cnt = `CNT_ZERO;
                end
                else
                begin
                    s_d.wd_cnt = s_q.wd_cnt + `CNT_ONE;
                end
            end
            ST_PULSE:
            begin
                s_d.wd_cnt = `CNT_ZERO;
                if (f.below_reset)
                begin
                    s_d.state = ST_POR;
                    s_d.rst_cnt = `CNT_ZERO;
                end
                else if (s_q.rst_cnt >= RESET_PULSE_CYC - `CNT_ONE)
                begin
                    s_d.state = ST_RUN;
                    s_d.rst_cnt = `CNT_ZERO;
                end
                else
                begin
                    s_d.rst_cnt = s_q.rst_cnt + `CNT_ONE;
                end
            end
            default:
            begin
                s_d.state = ST_POR;
                s_d.wd_cnt = `CNT_ZERO;
                s_d.rst_cnt = `CNT_ZERO;
            end
        endcase

        // supply select, with entry/exit hysteresis
        if (!s_q.on_batt)
        begin
            s_d.on_batt = f.below_switch & f.batt_above;
        end
        else
        begin
            s_d.on_batt = f.below_reset;
        end

        s_d.outs.reset_n = (s_d.state == ST_RUN);
        s_d.outs.reset_h = ~s_d.outs.reset_n;
        // warning path uses pfi_low and below_switch
        s_d.outs.pf_warn_n = ~f.pfi_low & ~f.below_switch;
        s_d.outs.on_battery = s_d.on_batt;
    end

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            s_q.state <= ST_POR;
            s_q.wd_cnt <= `CNT_ZERO;
            s_q.rst_cnt <= `CNT_ZERO;
            s_q.on_batt <= 1'b0;
            s_q.outs <= '{reset_n: 1'b0, reset_h: 1'b1, pf_warn_n: 1'b0, on_battery: 1'b0};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_status = s_q.outs;
endmodule

// ===== src/sync_2ff.sv
// two-flop synchroniser for a bundle of level inputs
// inputs are asynchronous to i_core_clk
`timescale 1ns/1ps
module sync_2ff #(
    parameter int WIDTH = 5
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s_q;
    sync_state_t s_d;

    always_comb
    begin
        s_d.meta = i_async;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign o_sync = s_q.stable;
endmodule

// ===== verif/host_kicker.sv
// host model: toggles the watchdog kick while enabled
// driven one ns after the clock edge
`timescale 1ns/1ps
module host_kicker #(
    parameter int HALF = 16
) (
    input wire logic i_core_clk,
    input wire logic i_en,
    output logic o_kick
);
    int n = 0;
    initial o_kick = 1'b0;
    always @(posedge i_core_clk)
    begin
        n <= (i_en && n < HALF - 1) ? n + 1 : 0;
        if (i_en && n == HALF - 1)
            o_kick <= #1 !o_kick; // service within one timeout
    end
endmodule

// ===== verif/supervisor_props.sv
// assertions on the supervisor core ports
// flags reach the outputs three clocks after the pin
`timescale 1ns/1ps
module supervisor_props
    import supervisor_pkg::*;
#(
    parameter logic [31:0] WD_TIMEOUT_CYC = 32'h28,
    parameter logic [31:0] RESET_PULSE_CYC = 32'hA
) (
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_watchdog_kick_in,
    input wire analog_flags_t i_flags,
    input wire sup_outs_t o_status
);
    logic [31:0] lo_q;
    logic [31:0] hi_q;
    logic [2:0] up_q;
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rstn);
    // low and high run lengths of the reset output
    always_ff @(posedge i_core_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            lo_q <= 32'h0;
            hi_q <= 32'h0;
            up_q <= 3'h0;
        end
        else
        begin
            lo_q <= o_status.reset_n ? 32'h0 : lo_q + 32'h1;
            hi_q <= o_status.reset_n ? hi_q + 32'h1 : 32'h0;
            up_q <= up_q + {2'h0, up_q != 3'h4};
        end
    end
    a_reset_inverse: assert property (o_status.reset_h == !o_status.reset_n)
        else $error("active-high reset not inverse");
    a_pf_warn_map: assert property (up_q == 3'h4 |-> o_status.pf_warn_n ==
        !($past(i_flags.pfi_low, 3) | $past(i_flags.below_switch, 3)))
        else $error("power-fail warning wrong");
    a_batt_entry: assert property ($rose(o_status.on_battery) |->
        $past(i_flags.below_switch, 3) && $past(i_flags.batt_above, 3))
        else $error("battery entered wrongly");
    a_batt_exit: assert property ($fell(o_status.on_battery) |->
        !$past(i_flags.below_reset, 3))
        else $error("battery left too early");
    a_batt_hold: assert property ($past(o_status.on_battery) &&
        $past(i_flags.below_reset, 3) |-> o_status.on_battery)
        else $error("battery not held");
    a_uv_holds: assert property (up_q == 3'h4 && $past(i_flags.below_reset, 3)
        |-> !o_status.reset_n)
        else $error("reset not held in undervoltage");
    a_reset_cause: assert property ($fell(o_status.reset_n) |->
        $past(i_flags.below_reset, 3) || hi_q >= WD_TIMEOUT_CYC)
        else $error("reset without cause");
    a_pulse_len: assert property ($rose(o_status.reset_n) |->
        lo_q >= RESET_PULSE_CYC)
        else $error("reset pulse too short");
    c_reset_fall: cover property ($fell(o_status.reset_n));
    c_batt_on: cover property ($rose(o_status.on_battery));
    c_pf_low: cover property ($fell(o_status.pf_warn_n));
endmodule
bind supervisor_watchdog_reset supervisor_props #(.WD_TIMEOUT_CYC(WD_TIMEOUT_CYC),
    .RESET_PULSE_CYC(RESET_PULSE_CYC)) props_i (.i_core_clk(i_core_clk),
    .i_rstn(i_rstn), .i_watchdog_kick_in(i_watchdog_kick_in), .i_flags(i_flags),
    .o_status(o_status));

// ===== verif/testbench.sv
// self-checking bench for the supervisor core
// short counts: timeout 40, pulse 10
`timescale 1ns/1ps
module testbench;
    import supervisor_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic kick_en = 1'b0;
    logic kick;
    analog_flags_t i_flags = '0;
    sup_outs_t o_status;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;
    int n;
    always #5 i_core_clk = ~i_core_clk;
    supervisor_watchdog_reset #(.WD_TIMEOUT_CYC(32'h28), .RESET_PULSE_CYC(32'hA))
    supervisor_watchdog_reset_i (.i_core_clk(i_core_clk), .i_rstn(i_rstn),
        .i_watchdog_kick_in(kick), .i_flags(i_flags), .o_status(o_status));
    host_kicker #(.HALF(20)) host_kicker_i (.i_core_clk(i_core_clk), .i_en(kick_en),
        .o_kick(kick));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        if (err_count == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge i_core_clk);
        #1;
    endtask
    // cycles until reset output reaches lvl
    task automatic run_to(input logic lvl);
        n = 0;
        while (o_status.reset_n !== lvl && n < 500)
        begin
            tick(1);
            n++;
        end
    endtask
    task automatic t_static();
        run_to(1'b0);
        chk(32'(n), 32'h28);
        chk(32'(o_status.reset_h), 32'h1);
        run_to(1'b1);
        chk(32'(n), 32'hA);
        run_to(1'b0);
        chk(32'(n), 32'h28);
        run_to(1'b1);
    endtask
    task automatic t_kick();
        int lows = 0;
        kick_en = 1'b1;
        repeat (160)
        begin
            tick(1);
            lows += (o_status.reset_n !== 1'b1);
        end
        chk(32'(lows), 32'h0);
    endtask
    task automatic t_uv();
        i_flags.below_reset = 1'b1;
        tick(4);
        chk(32'(o_status.reset_n), 32'h0);
        i_flags.below_reset = 1'b0;
        tick(5);
        i_flags.below_reset = 1'b1;
        tick(4);
        i_flags.below_reset = 1'b0;
        run_to(1'b1);
        chk(32'(n >= 10), 32'h1);
    endtask
    task automatic t_pf();
        for (int i = 0; i < 4; i++)
        begin
            i_flags = '0;
            i_flags.pfi_low = i[0];
            i_flags.below_switch = i[1];
            tick(4);
            chk(32'(o_status.pf_warn_n), 32'(!(i[0] | i[1])));
            chk(32'(o_status.reset_n), 32'h1);
        end
        i_flags = 4'b0001;
        tick(4);
        chk(32'(o_status.on_battery), 32'h0);
        i_flags = 4'b1101;
        tick(4);
        chk(32'(o_status.on_battery), 32'h1);
        i_flags = 4'b1001;
        tick(4);
        chk(32'(o_status.on_battery), 32'h1);
        i_flags = 4'b0001;
        tick(4);
        chk(32'(o_status.on_battery), 32'h0);
    endtask
    always @(posedge i_core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            err_count++;
            print_verdict();
        end
    end
    initial
    begin
        tick(5);
        i_rstn = 1'b1;
        run_to(1'b1);
        chk(32'(n >= 10), 32'h1);
        t_static();
        t_kick();
        t_pf();
        t_uv();
        print_verdict();
    end
endmodule
